// ===== rtl/dss_pkg.sv
// Constants for the drum slot sequencer: counts, register map, fields
package dss_pkg;

  // Drum format counts
  localparam logic [5:0] BIT_LAST    = 6'h2E;  // Count 46, then forced to ones
  localparam logic [5:0] BIT_ONES    = 6'h3F;
  localparam logic [4:0] SLOT_LAST   = 5'h18;  // Word 24, 25 words a channel
  localparam logic [4:0] SLOT_ONES   = 5'h1F;
  localparam logic [4:0] TCNT_LAST   = 5'h18;  // Input count 24
  localparam logic [5:0] CHAN_LAST   = 6'h3B;  // Channel 59, sixty channels
  localparam int         TAP_STAGES  = 5;

  // Register word addresses
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_CMD     = 4'h1;
  localparam logic [3:0] REG_LIMITS  = 4'h2;
  localparam logic [3:0] REG_TEST_LO = 4'h3;
  localparam logic [3:0] REG_TEST_HI = 4'h4;
  localparam logic [3:0] REG_STATUS  = 4'h5;

  // Control register fields
  localparam int CTRL_WRITE   = 0;
  localparam int CTRL_TEST    = 1;
  localparam int CTRL_AUTO    = 2;
  localparam int CTRL_REPEAT  = 3;
  localparam int CTRL_RUN     = 4;
  localparam int CTRL_TAP_LSB = 5;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // Command register fields, one-cycle actions
  localparam int CMD_CLEAR = 0;
  localparam int CMD_STEP  = 1;
  localparam int CMD_UP    = 2;
  localparam int CMD_DOWN  = 3;

  // Limit register fields, two octal digits each
  localparam int LIM_LOWER_LSB = 0;
  localparam int LIM_UPPER_LSB = 8;
  localparam logic [5:0] LOWER_RESET = 6'h00;
  localparam logic [5:0] UPPER_RESET = 6'h3B;

  // Status register fields
  localparam int ST_BIT_LSB  = 0;
  localparam int ST_SLOT_LSB = 8;
  localparam int ST_TCNT_LSB = 16;
  localparam int ST_CHAN_LSB = 24;
  localparam int ST_DIR      = 30;
  localparam int ST_GATE     = 31;

endpackage

// ===== rtl/dss_sequencer.sv
// Drum slot sequencer: bit, slot, input word and channel counting
`timescale 1ns/1ps
//
// Function
// - Bit counter makes one word boundary per 48 timing clocks.
// - Bit counter forced to ones after count 46, next clock gives zero.
// - Sync pulse forces the bit counter to all ones.
// - Slot counter advances each word boundary, 25 words then restart.
// - Slot counter resets to all ones so next advance gives zero.
// - Bit and slot counters run whenever the drum turns.
// - Input word counter steps once per word-ready, up or down.
// - Input counter wraps 24 to 0 or 0 to 24, stepping channel.
// - Clear button zeroes input word and channel counters.
// - Counter match opens a 48-bit-time word gate.
// - Inhibit passes only one gate per input counter value.
// - Sync inhibits the comparator during slot reset.
// - Channel counter recycles after sixty channels, selects channel.
// - Channel wraps 59 to 0 going up, 0 to 59 going down.
// - Write mode counts up only; read mode follows direction flop.
// - Direction flop set by scan limits or up/down buttons.
// - At a scan limit in read mode, reverse and replay backwards.
// - Stopped run gate blocks word-ready, gate and channel stepping.
// - Test mode takes the 48-bit test word as data source.
// - Auto test stepping uses a selected stage of a sync counter.
// - Manual test step moves exactly one word.
// - Repeat word button disconnects the one-gate inhibit.

module dss_sequencer #(
  parameter int WORD_BITS = 48
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 timing_pin,
  input  wire logic                 sync_pin,
  input  wire logic                 word_ready_pin,
  input  wire logic [WORD_BITS-1:0] ext_word,
  output logic                      word_gate,
  output logic      [WORD_BITS-1:0] gate_word,
  output logic      [4:0]           slot,
  output logic      [4:0]           word_count,
  output logic      [5:0]           channel,
  output logic                      direction_flip_flop
);

  // Test word is two 32-bit halves, so the width must fit in 33..64
  if (WORD_BITS < 33 || WORD_BITS > 64) begin : g_bad_width
    $error("WORD_BITS must lie in 33..64");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, change taken when stages 2 and 3 agree

  logic [2:0] pin_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic       timing_p;
  logic       sync_p;
  logic       ready_p;

  assign pin_in = {word_ready_pin, sync_pin, timing_pin};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1[i]     <= 1'b0;
          sync2[i]     <= 1'b0;
          sync3[i]     <= 1'b0;
          pin_level[i] <= 1'b0;
          pin_rise[i]  <= 1'b0;
        end else begin
          sync1[i] <= pin_in[i];
          sync2[i] <= sync1[i];
          sync3[i] <= sync2[i];
          if (sync2[i] == sync3[i]) begin
            pin_level[i] <= sync3[i];
          end
          pin_rise[i] <= sync2[i] & sync3[i] & ~pin_level[i];
        end
      end
    end
  endgenerate

  assign timing_p = pin_rise[0];
  assign sync_p   = pin_rise[1];
  assign ready_p  = pin_rise[2];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [7:0]  ctrl;
  logic [5:0]  lower_limit;
  logic [5:0]  upper_limit;
  logic [63:0] test_word;
  logic        cmd_wr;
  logic        clear_cmd;
  logic        step_cmd;
  logic        up_cmd;
  logic        down_cmd;
  logic        write_mode;
  logic        test_mode;
  logic        auto_step;
  logic        repeat_word_button;
  logic        run_gate_flip_flop;
  logic [2:0]  tap_sel;

  assign cmd_wr    = reg_wr && reg_addr == dss_pkg::REG_CMD;
  assign clear_cmd = cmd_wr && reg_wdata[dss_pkg::CMD_CLEAR];
  assign step_cmd  = cmd_wr && reg_wdata[dss_pkg::CMD_STEP];
  assign up_cmd    = cmd_wr && reg_wdata[dss_pkg::CMD_UP];
  assign down_cmd  = cmd_wr && reg_wdata[dss_pkg::CMD_DOWN];

  assign write_mode         = ctrl[dss_pkg::CTRL_WRITE];
  assign test_mode          = ctrl[dss_pkg::CTRL_TEST];
  assign auto_step          = ctrl[dss_pkg::CTRL_AUTO];
  assign repeat_word_button = ctrl[dss_pkg::CTRL_REPEAT];
  assign run_gate_flip_flop = ctrl[dss_pkg::CTRL_RUN];
  assign tap_sel            = ctrl[dss_pkg::CTRL_TAP_LSB +: 3];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl        <= dss_pkg::CTRL_RESET;
      lower_limit <= dss_pkg::LOWER_RESET;
      upper_limit <= dss_pkg::UPPER_RESET;
      test_word   <= 64'h0000_0000_0000_0000;
    end else if (reg_wr) begin
      if (reg_addr == dss_pkg::REG_CTRL) begin
        ctrl <= reg_wdata[7:0];
      end else if (reg_addr == dss_pkg::REG_LIMITS) begin
        lower_limit <= reg_wdata[dss_pkg::LIM_LOWER_LSB +: 6];
        upper_limit <= reg_wdata[dss_pkg::LIM_UPPER_LSB +: 6];
      end else if (reg_addr == dss_pkg::REG_TEST_LO) begin
        test_word[31:0] <= reg_wdata;
      end else if (reg_addr == dss_pkg::REG_TEST_HI) begin
        test_word[63:32] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit and slot counters, free running with the drum

  logic [5:0] bit_pos;
  logic [4:0] next_slot;
  logic       word_edge;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_pos <= dss_pkg::BIT_ONES;
    end else if (sync_p) begin
      bit_pos <= dss_pkg::BIT_ONES;
    end else if (timing_p) begin
      if (bit_pos == dss_pkg::BIT_LAST) begin
        bit_pos <= dss_pkg::BIT_ONES;
      end else begin
        bit_pos <= bit_pos + 6'h01;
      end
    end
  end

  // Boundary is the ones-to-zero roll, so the slot starts with its bit 0
  assign word_edge = timing_p && !sync_p && bit_pos == dss_pkg::BIT_ONES;
  assign next_slot = (slot == dss_pkg::SLOT_LAST) ? 5'h00 : slot + 5'h01;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot <= dss_pkg::SLOT_ONES;
    end else if (sync_p) begin
      slot <= dss_pkg::SLOT_ONES;
    end else if (word_edge) begin
      slot <= next_slot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word-ready sources: external pin, auto test divider, manual step

  logic [4:0] tap_cnt;
  logic       tap_prev;
  logic       tap_bit;
  logic       ready_raw;
  logic       step;

  assign tap_bit = (tap_sel >= 3'(dss_pkg::TAP_STAGES)) ?
                   tap_cnt[dss_pkg::TAP_STAGES-1] : tap_cnt[tap_sel];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tap_cnt  <= 5'h00;
      tap_prev <= 1'b0;
    end else begin
      if (sync_p) begin
        tap_cnt <= tap_cnt + 5'h01;
      end
      tap_prev <= tap_bit;
    end
  end

  always_comb begin
    if (!test_mode) begin
      ready_raw = ready_p;
    end else if (auto_step) begin
      ready_raw = tap_bit && !tap_prev;
    end else begin
      ready_raw = step_cmd;
    end
  end

  // Stopped run gate swallows every word-ready pulse
  assign step = ready_raw && run_gate_flip_flop && !clear_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Input word counter, channel counter and direction

  logic count_up;
  logic at_upper;
  logic at_lower;

  assign count_up = write_mode || direction_flip_flop;
  // Limit reached: reverse inside the channel rather than leave it
  assign at_upper = !write_mode && count_up && channel == upper_limit &&
                    word_count == dss_pkg::TCNT_LAST;
  assign at_lower = !write_mode && !count_up && channel == lower_limit &&
                    word_count == 5'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_count <= 5'h00;
      channel    <= 6'h00;
    end else if (clear_cmd) begin
      word_count <= 5'h00;
      channel    <= 6'h00;
    end else if (step) begin
      if (at_upper) begin
        word_count <= dss_pkg::TCNT_LAST - 5'h01;
      end else if (at_lower) begin
        word_count <= 5'h01;
      end else if (count_up) begin
        if (word_count == dss_pkg::TCNT_LAST) begin
          word_count <= 5'h00;
          if (channel == dss_pkg::CHAN_LAST) begin
            channel <= 6'h00;
          end else begin
            channel <= channel + 6'h01;
          end
        end else begin
          word_count <= word_count + 5'h01;
        end
      end else begin
        if (word_count == 5'h00) begin
          word_count <= dss_pkg::TCNT_LAST;
          if (channel == 6'h00) begin
            channel <= dss_pkg::CHAN_LAST;
          end else begin
            channel <= channel - 6'h01;
          end
        end else begin
          word_count <= word_count - 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      direction_flip_flop <= 1'b1;
    end else if (up_cmd) begin
      direction_flip_flop <= 1'b1;
    end else if (down_cmd) begin
      direction_flip_flop <= 1'b0;
    end else if (step && at_upper) begin
      direction_flip_flop <= 1'b0;
    end else if (step && at_lower) begin
      direction_flip_flop <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator gate with one-per-count inhibit

  logic armed;
  logic gate_open;

  assign gate_open = word_edge && run_gate_flip_flop &&
                     (armed || repeat_word_button) &&
                     next_slot == word_count;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (step) begin
      armed <= 1'b1; // New count wins over the same-cycle disarm
    end else if (gate_open && !repeat_word_button) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_gate <= 1'b0;
    end else if (sync_p) begin
      word_gate <= 1'b0;
    end else if (word_edge) begin
      word_gate <= gate_open;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_word <= '0;
    end else if (gate_open) begin
      gate_word <= test_mode ? test_word[WORD_BITS-1:0] : ext_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data valid only in the cycle after the strobe

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == dss_pkg::REG_CTRL) begin
      reg_rdata <= {24'h00_0000, ctrl};
    end else if (reg_addr == dss_pkg::REG_LIMITS) begin
      reg_rdata <= {18'h0_0000, upper_limit, 2'b00, lower_limit};
    end else if (reg_addr == dss_pkg::REG_TEST_LO) begin
      reg_rdata <= test_word[31:0];
    end else if (reg_addr == dss_pkg::REG_TEST_HI) begin
      reg_rdata <= test_word[63:32];
    end else if (reg_addr == dss_pkg::REG_STATUS) begin
      reg_rdata <= {word_gate, direction_flip_flop, channel,
                    3'b000, word_count, 3'b000, slot, 2'b00, bit_pos};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_bit_force_ones: assert property (@(posedge clk_sys) disable iff (rst)
    timing_p && !sync_p && bit_pos == 6'h2E |=> bit_pos == 6'h3F)
    else $error("bit counter not forced to ones after 46");

  a_sync_ones: assert property (@(posedge clk_sys) disable iff (rst)
    sync_p |=> bit_pos == 6'h3F && slot == 5'h1F)
    else $error("sync did not force counters to ones");

  a_slot_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    word_edge && slot == 5'h18 |=> slot == 5'h00)
    else $error("slot counter did not wrap after 24");

  a_tcnt_up_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    step && count_up && !at_upper && word_count == 5'h18
    |=> word_count == 5'h00 && channel != $past(channel))
    else $error("input counter up wrap did not step channel");

  a_chan_down_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    step && !count_up && !at_lower && word_count == 5'h00 && channel == 6'h00
    |=> channel == 6'h3B)
    else $error("channel did not wrap from 0 to 59");

  a_clear_zero: assert property (@(posedge clk_sys) disable iff (rst)
    clear_cmd |=> word_count == 5'h00 && channel == 6'h00)
    else $error("clear did not zero counters");

  a_gate_match: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(word_gate) |-> slot == word_count && run_gate_flip_flop)
    else $error("gate opened without counter match");

  a_one_gate: assert property (@(posedge clk_sys) disable iff (rst)
    gate_open && !repeat_word_button && !step
    |=> !armed)
    else $error("inhibit not armed off after gate");

  a_sync_gate: assert property (@(posedge clk_sys) disable iff (rst)
    sync_p |=> !word_gate)
    else $error("gate open through sync");

  a_stop_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !run_gate_flip_flop && !clear_cmd
    |=> $stable(word_count) && $stable(channel))
    else $error("counters moved while stopped");

  a_write_up: assert property (@(posedge clk_sys) disable iff (rst)
    write_mode && step && !clear_cmd && word_count != 5'h18
    |=> word_count == $past(word_count) + 5'h01)
    else $error("write mode did not count up");

  a_limit_turn: assert property (@(posedge clk_sys) disable iff (rst)
    step && at_upper && !up_cmd && !down_cmd
    |=> !direction_flip_flop && channel == $past(channel))
    else $error("no reversal at upper scan limit");

  a_chan_range: assert property (@(posedge clk_sys) disable iff (rst)
    channel <= 6'h3B)
    else $error("channel beyond 59");

endmodule // dss_sequencer

// ===== bench/dss_drum_model.sv
// Drum sync and timing track model for the sequencer bench
`timescale 1ns/1ps
module dss_drum_model #(
  parameter int GAP_NS = 3200,  // Sync to timing gap, scaled down for run time
  parameter int CLOCKS = 1216
) (
  input  wire logic drum_on,
  output logic      timing_pin,
  output logic      sync_pin
);
  // Track stands still outside frames; 7 ns skew keeps phase unrelated
  initial begin
    timing_pin = 1'h0;
    sync_pin   = 1'h0;
    #7;
    forever begin
      wait (drum_on);
      sync_pin = 1'h1;
      #100 sync_pin = 1'h0;
      #GAP_NS;
      repeat (CLOCKS) begin
        timing_pin = 1'h1;
        #100 timing_pin = 1'h0;
        #100;
      end
      #GAP_NS;
    end
  end
endmodule // dss_drum_model

// ===== bench/drum_slot_sequencer_tb.sv
// Self-checking bench for the drum slot sequencer
`timescale 1ns/1ps
module drum_slot_sequencer_tb;
  logic        clk_sys        = 1'h0;
  logic        rst            = 1'h1;
  logic [3:0]  reg_addr       = 4'h0;
  logic [31:0] reg_wdata      = 32'h0000_0000;
  logic        reg_wr         = 1'h0;
  logic        reg_rd         = 1'h0;
  logic        word_ready_pin = 1'h0;
  logic [47:0] ext_word       = 48'h0F0F_0F0F_0F0F;
  logic        drum_on        = 1'h0;
  logic        gate_q         = 1'h0;
  logic [31:0] reg_rdata;
  logic        timing_pin;
  logic        sync_pin;
  logic        word_gate;
  logic [47:0] gate_word;
  logic [4:0]  slot;
  logic [4:0]  word_count;
  logic [5:0]  channel;
  logic        direction_flip_flop;
  logic [31:0] d;
  int          n_fail     = 0;
  int          num_checks = 0;
  int          n_gates    = 0;
  int          tcount     = 0;
  logic [3:0]  ra [4] = '{4'h0, 4'h2, 4'h1, 4'hF};
  logic [31:0] rv [4] = '{32'h0000_0001, 32'h0000_3B00, 32'h0, 32'h0};

  always #12.5 clk_sys = ~clk_sys;

  dss_sequencer #(.WORD_BITS(48)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timing_pin(timing_pin), .sync_pin(sync_pin),
    .word_ready_pin(word_ready_pin), .ext_word(ext_word),
    .word_gate(word_gate), .gate_word(gate_word), .slot(slot),
    .word_count(word_count), .channel(channel),
    .direction_flip_flop(direction_flip_flop)
  );

  dss_drum_model drum (
    .drum_on(drum_on), .timing_pin(timing_pin), .sync_pin(sync_pin)
  );

  ////////////////////////////////////////////////////////////
  always @(posedge sync_pin) tcount = 0;
  always @(posedge timing_pin) tcount++;

  // Sampled on the falling edge to stay clear of design updates
  always @(negedge clk_sys) begin
    gate_q <= word_gate;
    if (word_gate === 1'h1 && gate_q === 1'h0) begin
      n_gates++;
      chk({43'h0, slot}, {43'h0, word_count});
    end
  end

  ////////////////////////////////////////////////////////////
  task chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_fail++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("Checks %0d, failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask

  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task cmd(input logic [31:0] v);
    wr(dss_pkg::REG_CMD, v);
  endtask

  // Polls with a bound so a dead drum ends the run
  task wait_pin(input logic s, input logic lvl);
    int i;
    i = 0;
    while (((s ? sync_pin : timing_pin) !== lvl) && i < 12000) begin
      @(posedge clk_sys);
      i++;
    end
    if (i >= 12000) begin
      n_fail++;
      $display("Error at %0t: drum pin wait timed out", $time);
      wrap_up();
    end
  endtask

  task wait_sync;
    wait_pin(1'h1, 1'h0);
    wait_pin(1'h1, 1'h1);
  endtask

  task pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      word_ready_pin <= 1'h1;
      repeat (3) @(posedge clk_sys);
      word_ready_pin <= 1'h0;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  task chk_cnt(input logic [4:0] w, input logic [5:0] c);
    repeat (4) @(posedge clk_sys);
    #1 chk({37'h0, channel, word_count}, {37'h0, c, w});
  endtask

  task chk_dir(input logic u);
    repeat (2) @(posedge clk_sys);
    #1 chk({47'h0, direction_flip_flop}, {47'h0, u});
  endtask

  task chk_drum;
    logic [5:0] b;
    logic [4:0] w;
    b = (tcount == 0 || (tcount - 1) % 48 == 47) ? 6'h3F
        : 6'((tcount - 1) % 48);
    w = (tcount == 0) ? 5'h1F : 5'(((tcount - 1) / 48) % 25);
    @(posedge clk_sys);
    rd(dss_pkg::REG_STATUS);
    chk({37'h0, d[12:8], d[5:0]}, {37'h0, w, b});
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    chk_cnt(5'h00, 6'h00);
    chk({43'h0, slot}, 48'h1F);
    for (int i = 0; i < 4; i++) begin
      rd(ra[i]);
      chk({16'h0, d}, {16'h0, rv[i]});
    end
    @(posedge clk_sys);
    #1 chk({16'h0, reg_rdata}, 48'h0);
    drum_on <= 1'h1;
    wait_pin(1'h1, 1'h1);
    wait_pin(1'h1, 1'h0);
    chk_drum();
    repeat (1216) begin
      wait_pin(1'h0, 1'h1);
      wait_pin(1'h0, 1'h0);
      chk_drum();
    end
    // Counting through the word-ready pin
    pulse(3);
    chk_cnt(5'h00, 6'h00);
    wr(dss_pkg::REG_CTRL, 32'h0000_0011);
    cmd(32'h0000_0008);
    pulse(1);
    chk_cnt(5'h01, 6'h00);
    cmd(32'h0000_0004);
    pulse(1498);
    chk_cnt(5'h18, 6'h3B);
    pulse(1);
    chk_cnt(5'h00, 6'h00);
    wr(dss_pkg::REG_CTRL, 32'h0000_0010);
    wr(dss_pkg::REG_LIMITS, 32'h0000_2408);
    cmd(32'h0000_0008);
    chk_dir(1'h0);
    pulse(1);
    chk_cnt(5'h18, 6'h3B);
    cmd(32'h0000_0004);
    chk_dir(1'h1);
    pulse(2);
    chk_cnt(5'h01, 6'h00);
    cmd(32'h0000_0001);
    chk_cnt(5'h00, 6'h00);
    wr(dss_pkg::REG_LIMITS, 32'h0000_0000);
    pulse(25);
    chk_cnt(5'h17, 6'h00);
    chk_dir(1'h0);
    pulse(24);
    chk_cnt(5'h01, 6'h00);
    chk_dir(1'h1);
    // Test source, manual step, then repeat word
    wr(dss_pkg::REG_CTRL, 32'h0000_0013);
    wr(dss_pkg::REG_TEST_LO, 32'h89AB_CDEF);
    wr(dss_pkg::REG_TEST_HI, 32'h0000_4567);
    rd(dss_pkg::REG_TEST_LO);
    chk({16'h0, d}, 48'h0000_89AB_CDEF);
    cmd(32'h0000_0001);
    wait_sync();
    n_gates = 0;
    cmd(32'h0000_0002);
    chk_cnt(5'h01, 6'h00);
    wait_sync();
    wait_sync();
    chk_n(n_gates, 1);
    chk(gate_word, 48'h4567_89AB_CDEF);
    wr(dss_pkg::REG_CTRL, 32'h0000_001B);
    n_gates = 0;
    wait_sync();
    wait_sync();
    chk_n(n_gates, 2);
    // Auto stepping from sync stage 0: one rise per two syncs
    wait_pin(1'h0, 1'h1);
    wr(dss_pkg::REG_CTRL, 32'h0000_0017);
    wait_sync();
    wait_sync();
    repeat (20) @(posedge clk_sys);
    chk_cnt(5'h02, 6'h00);
    wrap_up();
  end
endmodule // drum_slot_sequencer_tb
